// >>> fam_pkg.sv
package fam_pkg;

  // ----------------------------------------------------------------------
  // Access modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FAM_MODE_W64 = 2'h0,
    FAM_MODE_W32 = 2'h1,
    FAM_MODE_H16 = 2'h2,
    FAM_MODE_EXT = 2'h3
  } fam_mode_t;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int FAM_BIG_SECTORS = 16;
  localparam int FAM_SMALL_SECTORS = 8;
  localparam int FAM_BIG_KB = 64;
  localparam int FAM_SMALL_KB = 8;
  localparam int FAM_TOTAL_KB = FAM_BIG_SECTORS * FAM_BIG_KB
                              + FAM_SMALL_SECTORS * FAM_SMALL_KB;
  localparam int FAM_ADDR_W = 21;
  localparam logic [20:0] FAM_BASE = 21'h040000;
  localparam logic [20:0] FAM_BIG_END = 21'h140000;
  localparam logic [20:0] FAM_END = 21'h150000;
  localparam int FAM_SMALL_SHIFT = 13;
  localparam int FAM_ROWS = 64;

  // ----------------------------------------------------------------------
  // Security vector and boot routine
  // ----------------------------------------------------------------------
  localparam logic [20:0] FAM_SV_LO = 21'h148000;
  localparam logic [20:0] FAM_SV_HI = 21'h14800F;
  localparam int FAM_SV_GLOBAL_BIT = 17;
  localparam logic [15:0] FAM_BOOT_ENTRY = 16'hBF60;
  localparam logic [2:0] FAM_EXT_PINS = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int FAM_WAIT_W = 4;
  localparam logic [3:0] FAM_WAIT_RST = 4'h1;

  // Small sector index of a byte address inside the top region
  function automatic logic [2:0] fam_small_idx(input logic [20:0] a);
    fam_small_idx = 3'((a - FAM_BIG_END) >> FAM_SMALL_SHIFT);
  endfunction

endpackage

// >>> fam_array.sv
`timescale 1ns/10ps
// Flash array model, 64-bit rows with 16-bit lane write enables
module fam_array
  import fam_pkg::*;
(
  input wire logic clk,
  input wire logic [5:0] row,
  input wire logic [3:0] lane_we,
  input wire logic [63:0] wdata,
  output logic [63:0] rdata
);

  logic [63:0] mem [FAM_ROWS];

  // ----------------------------------------------------------------------
  // Synchronous read and lane write
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (lane_we[i]) begin
        mem[row][i*16 +: 16] <= wdata[i*16 +: 16];
      end
    end
    rdata <= mem[row];
  end

endmodule

// >>> fam_core.sv
`timescale 1ns/10ps
module fam_core
  import fam_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] boot_mode_select_pins,
  input wire logic [FAM_WAIT_W-1:0] wait_states,
  input wire logic [15:0] cpu_pc,
  input wire logic mode_req_valid,
  input wire logic [1:0] mode_req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic req_half,
  input wire logic [20:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic resp_error,
  output logic cpu_halt,
  output logic [1:0] mode,
  output logic sv_hit,
  output logic [17:0] sector_protect_vector_word,
  input wire logic ext_we_n,
  input wire logic [20:0] ext_addr,
  input wire logic [15:0] ext_dq_in,
  output logic [15:0] ext_dq_out,
  output logic ext_dq_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FAM_IDLE = 2'h0,
    FAM_WAIT = 2'h1,
    FAM_READ = 2'h3,
    FAM_DONE = 2'h2
  } fam_state_t;

  typedef struct packed {
    fam_state_t st;
    fam_mode_t mode;
    logic strap_done;
    logic [FAM_WAIT_W-1:0] cnt;
    logic wr;
    logic half;
    logic [20:0] addr;
    logic [31:0] wdata;
    logic rvalid;
    logic [31:0] rdata;
    logic rerr;
    logic [17:0] sv;
    logic svhit;
    logic [15:0] dq;
  } fam_reg_t;

  fam_reg_t r;
  fam_reg_t next_r;

  logic [63:0] arr_rdata;
  logic [5:0] arr_row;
  logic [3:0] arr_we;
  logic [63:0] arr_wdata;
  logic in_range;
  logic prot;
  logic bad;

  // Half-word lane of a byte address. The lower address is the upper half
  // of each 32-bit word, so half-word and word views agree.
  function automatic logic [1:0] fam_lane(input logic [20:0] a);
    fam_lane = {a[2], !a[1]};
  endfunction

  fam_array u_array (
    .clk(clk),
    .row(arr_row),
    .lane_we(arr_we),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  // ----------------------------------------------------------------------
  // Decode of the pending request
  // ----------------------------------------------------------------------
  // Top 64K of the array range holds the 8K sectors, below them 64K sectors
  always_comb begin
    in_range = (req_addr >= FAM_BASE) && (req_addr < FAM_END);
    prot = 1'b0;
    // Small sector lock, zero protects, only under global enable
    if (req_addr >= FAM_BIG_END && r.sv[FAM_SV_GLOBAL_BIT]) begin
      prot = !r.sv[fam_small_idx(req_addr)];
    end
    bad = !in_range
        || (req_write && r.mode == FAM_MODE_W64)
        || (req_write && r.mode == FAM_MODE_W32)
        || (req_fetch && r.mode == FAM_MODE_H16)
        || (req_write && prot)
        || (r.mode != FAM_MODE_H16 && req_half)
        || (r.mode == FAM_MODE_H16 && !req_half);
  end

  assign req_ready = (r.st == FAM_IDLE) && r.strap_done
                   && (r.mode != FAM_MODE_EXT);

  // ----------------------------------------------------------------------
  // Array port steering
  // ----------------------------------------------------------------------
  // Row from address bits 8:3 in every mode, of ext_addr in external mode; lane enables and read mux differ
  always_comb begin
    arr_row = r.addr[8:3];
    arr_we = 4'h0;
    arr_wdata = {r.wdata, r.wdata};
    if (r.mode == FAM_MODE_EXT) begin
      arr_row = ext_addr[8:3];
      arr_wdata = {4{ext_dq_in}};
      if (!ext_we_n) begin
        arr_we = 4'h1 << fam_lane(ext_addr);
      end
    end else if (r.st == FAM_WAIT && r.cnt == '0 && r.wr) begin
      // Only writes accepted in 16-bit mode can reach here; one half-word lane
      arr_we = 4'h1 << fam_lane(r.addr);
      arr_wdata = {4{r.wdata[15:0]}};
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    // Straps caught once after reset release, not under the reset
    if (!r.strap_done) begin
      next_r.strap_done = 1'b1;
      if (boot_mode_select_pins == FAM_EXT_PINS) begin
        next_r.mode = FAM_MODE_EXT;
      end
    end
    // Mode change only through the boot routine
    // Not before the straps are taken, so a request cannot override them
    if (mode_req_valid && cpu_pc == FAM_BOOT_ENTRY && r.strap_done
        && r.st == FAM_IDLE && r.mode != FAM_MODE_EXT) begin
      next_r.mode = fam_mode_t'(mode_req == 2'(FAM_MODE_EXT)
                    ? 2'(FAM_MODE_W32) : mode_req);
    end
    case (r.st)
      FAM_IDLE: begin
        if (req_valid && req_ready) begin
          next_r.addr = req_addr;
          next_r.wr = req_write;
          next_r.half = req_half;
          next_r.wdata = req_wdata;
          next_r.svhit = (req_addr >= FAM_SV_LO)
                       && (req_addr <= FAM_SV_HI);
          if (bad) begin
            next_r.rerr = 1'b1;
            next_r.rdata = '0;
            next_r.st = FAM_DONE;
          end else begin
            next_r.rerr = 1'b0;
            next_r.cnt = wait_states;
            next_r.st = FAM_WAIT;
          end
        end
      end
      FAM_WAIT: begin
        if (r.cnt == '0) begin
          next_r.st = FAM_READ;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      FAM_READ: begin
        // One 64-bit row fetch in every mode; word or half picked out
        case (r.mode)
          FAM_MODE_W64: next_r.rdata = r.addr[2]
                          ? arr_rdata[63:32] : arr_rdata[31:0];
          FAM_MODE_W32: next_r.rdata = r.addr[2]
                          ? arr_rdata[63:32] : arr_rdata[31:0];
          FAM_MODE_H16: next_r.rdata = {16'h0000,
                          arr_rdata[fam_lane(r.addr)*16 +: 16]};
          default: next_r.rdata = '0;
        endcase
        // A read of the vector word loads the protection settings
        if (r.svhit && !r.wr && r.addr[3:0] == 4'h0) begin
          // Whole word from the row, so a half-word read loads it too
          next_r.sv = arr_rdata[17:0];
        end
        next_r.st = FAM_DONE;
      end
      FAM_DONE: begin
        next_r.rvalid = 1'b1;
        next_r.st = FAM_IDLE;
      end
      default: next_r.st = FAM_IDLE;
    endcase
    if (r.mode == FAM_MODE_EXT) begin
      next_r.dq = arr_rdata[fam_lane(ext_addr)*16 +: 16];
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: FAM_IDLE, mode: FAM_MODE_W32, sv: 18'h00000,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign resp_valid = r.rvalid;
  assign resp_rdata = r.rdata;
  assign resp_error = r.rerr;
  assign cpu_halt = (r.mode == FAM_MODE_EXT);
  assign mode = r.mode;
  assign sv_hit = r.svhit;
  assign sector_protect_vector_word = r.sv;
  assign ext_dq_out = r.dq;
  // Low enable drives the pins, only in external mode with write idle
  assign ext_dq_oe = !(cpu_halt && ext_we_n);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  no_wide_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.mode == FAM_MODE_W64 |-> arr_we == 4'h0)
    else $error("array written in wide mode");
  fetch_h16_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_fetch && r.mode == FAM_MODE_H16
    |-> ##2 resp_valid && resp_error)
    else $error("fetch in 16-bit mode not rejected");
  wait_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && !bad && wait_states == 4'h2
    |-> ##6 resp_valid && !resp_error)
    else $error("wait state count wrong");
  half_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.mode != FAM_MODE_EXT |-> $countones(arr_we) <= 1)
    else $error("more than one lane written");
  ext_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.mode == FAM_MODE_EXT |-> cpu_halt && !req_ready)
    else $error("cpu not halted in external mode");
  prot_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_write && prot
    |-> ##1 r.st == FAM_DONE && r.rerr)
    else $error("protected sector write accepted");
  sv_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_addr == FAM_SV_LO
    |-> ##1 sv_hit)
    else $error("vector range not flagged");
  mode_switch_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_req_valid && cpu_pc != FAM_BOOT_ENTRY && r.strap_done
    |=> $stable(mode))
    else $error("mode changed outside boot entry");

endmodule

// >>> fam_cpu_model.sv
`timescale 1ns/10ps
// Processor bus master: one request outstanding, held until accepted
module fam_cpu_model
  import fam_pkg::*;
(
  input wire logic clk,
  input wire logic req_ready,
  input wire logic resp_valid,
  output logic req_valid,
  output logic req_write,
  output logic req_fetch,
  output logic req_half,
  output logic [20:0] req_addr,
  output logic [31:0] req_wdata
);
  initial begin
    {req_valid, req_write, req_fetch, req_half} = 4'h0;
    req_addr = 21'h000000;
    req_wdata = 32'h00000000;
  end

  // Released valid, address and data lines show inverted values so a late sample cannot pass
  task automatic access(input logic w, f, h, input logic [20:0] a,
    input logic [31:0] d, output int lat);
    @(negedge clk);
    {req_valid, req_write, req_fetch, req_half} = {1'b1, w, f, h};
    req_addr = a;
    req_wdata = d;
    do @(posedge clk); while (req_ready !== 1'b1);
    lat = 0;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
    // Bounded so a lost response cannot hang the master
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (resp_valid !== 1'b1 && lat < 40);
  endtask
endmodule

// >>> fam_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
  import fam_pkg::*;
  logic clk, rst_n, mode_req_valid, req_valid, req_ready, req_write;
  logic req_fetch, req_half, resp_valid, resp_error, cpu_halt, sv_hit;
  logic ext_we_n, ext_dq_oe;
  logic [2:0] boot_mode_select_pins;
  logic [3:0] wait_states;
  logic [15:0] cpu_pc, ext_dq_in, ext_dq_out;
  logic [1:0] mode_req, mode;
  logic [20:0] req_addr, ext_addr;
  logic [31:0] req_wdata, resp_rdata;
  logic [17:0] sector_protect_vector_word;
  int err_total = 0, total_checks = 0, lat, cyc = 0;

  // ----------------------------------------------------------------
  // Design and processor model
  // ----------------------------------------------------------------
  fam_core dut (.clk, .rst_n, .boot_mode_select_pins, .wait_states,
    .cpu_pc, .mode_req_valid, .mode_req, .req_valid, .req_ready,
    .req_write, .req_fetch, .req_half, .req_addr, .req_wdata,
    .resp_valid, .resp_rdata, .resp_error, .cpu_halt, .mode, .sv_hit,
    .sector_protect_vector_word, .ext_we_n, .ext_addr, .ext_dq_in,
    .ext_dq_out, .ext_dq_oe);
  fam_cpu_model cpu (.clk, .req_ready, .resp_valid, .req_valid,
    .req_write, .req_fetch, .req_half, .req_addr, .req_wdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, well above the eighty or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Access helpers
  // ----------------------------------------------------------------
  task automatic acc(input logic w, f, h, input logic [20:0] a,
    input logic [31:0] d, input logic e, input int l);
    cpu.access(w, f, h, a, d, lat);
    `CHK("resp_error", e, resp_error)
    `CHK("latency", l, lat)
  endtask

  // Mode switch is only honoured from the boot routine entry
  task automatic setm(input logic [15:0] pc, input logic [1:0] m);
    @(negedge clk);
    cpu_pc = pc;
    mode_req = m;
    mode_req_valid = 1'b1;
    @(negedge clk);
    mode_req_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    boot_mode_select_pins = 3'h0;
    wait_states = 4'h0;
    {cpu_pc, mode_req, mode_req_valid} = 19'h00000;
    {ext_we_n, ext_addr, ext_dq_in} = {1'b1, 21'h000000, 16'h0000};
    repeat (4) @(posedge clk);
    `CHK("mode", 2'h1, mode)
    `CHK("ext_dq_oe", 1'b1, ext_dq_oe)
    @(negedge clk);
    rst_n = 1'b1;
    setm(16'h1234, 2'h2);
    `CHK("mode", 2'h1, mode)
    setm(FAM_BOOT_ENTRY, 2'h2);
    `CHK("mode", 2'h2, mode)
    wait_states = 4'h2;
    acc(1'b1, 1'b0, 1'b1, 21'h040008, 32'hAAAA1111, 1'b0, 5);
    wait_states = 4'h0;
    acc(1'b1, 1'b0, 1'b1, 21'h04000A, 32'h00002222, 1'b0, 3);
    acc(1'b0, 1'b0, 1'b1, 21'h04000A, 32'h0, 1'b0, 3);
    `CHK("rdata", 16'h2222, resp_rdata[15:0])
    acc(1'b0, 1'b1, 1'b1, 21'h040000, 32'h0, 1'b1, 1);
    // Vector word: global enable set, every small sector protected
    acc(1'b1, 1'b0, 1'b1, 21'h148000, 32'h00000002, 1'b0, 3);
    acc(1'b1, 1'b0, 1'b1, 21'h148002, 32'h00000000, 1'b0, 3);
    acc(1'b0, 1'b0, 1'b1, 21'h150000, 32'h0, 1'b1, 1);
    acc(1'b0, 1'b0, 1'b1, 21'h03FFFE, 32'h0, 1'b1, 1);
    setm(FAM_BOOT_ENTRY, 2'h0);
    `CHK("mode", 2'h0, mode)
    acc(1'b1, 1'b0, 1'b0, 21'h040008, 32'hDEADBEEF, 1'b1, 1);
    `CHK("rdata", 32'h0, resp_rdata)
    acc(1'b0, 1'b1, 1'b0, 21'h040008, 32'h0, 1'b0, 3);
    `CHK("rdata", 32'h11112222, resp_rdata)
    // Code 3 is no processor mode and falls back to the 32-bit mode
    setm(FAM_BOOT_ENTRY, 2'h3);
    `CHK("mode", 2'h1, mode)
    acc(1'b0, 1'b0, 1'b0, 21'h148000, 32'h0, 1'b0, 3);
    `CHK("sv_hit", 1'b1, sv_hit)
    `CHK("vector", 18'h20000, sector_protect_vector_word)
    acc(1'b1, 1'b0, 1'b0, 21'h040008, 32'h12345678, 1'b1, 1);
    acc(1'b0, 1'b1, 1'b0, 21'h040008, 32'h0, 1'b0, 3);
    `CHK("rdata", 32'h11112222, resp_rdata)
    `CHK("sv_hit", 1'b0, sv_hit)
    setm(FAM_BOOT_ENTRY, 2'h2);
    acc(1'b1, 1'b0, 1'b1, 21'h14A000, 32'h00005555, 1'b1, 1);
    acc(1'b1, 1'b0, 1'b1, 21'h040004, 32'h00005555, 1'b0, 3);
    // Second reset with all straps high selects external access
    @(negedge clk);
    rst_n = 1'b0;
    boot_mode_select_pins = FAM_EXT_PINS;
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("cpu_halt", 1'b1, cpu_halt)
    `CHK("mode", 2'h3, mode)
    `CHK("req_ready", 1'b0, req_ready)
    {ext_addr, ext_dq_in, ext_we_n} = {21'h040010, 16'h5A5A, 1'b0};
    @(negedge clk);
    {ext_dq_in, ext_we_n} = {16'hA5A5, 1'b1};
    repeat (2) @(negedge clk);
    `CHK("ext_dq_out", 16'h5A5A, ext_dq_out)
    `CHK("ext_dq_oe", 1'b0, ext_dq_oe)
    results();
  end
endmodule
